/* verilog/t0c_params.svh */
// Register indices, field positions, reset values and count limits of the timer
`ifndef T0C_PARAMS_SVH
`define T0C_PARAMS_SVH
`define T0C_IDX_CTRL_A 8'h2a
`define T0C_IDX_GCTL 8'h2c
`define T0C_IDX_CTRL_B 8'h30
`define T0C_IDX_CMP_A 8'h31
`define T0C_IDX_CMP_B 8'h32
`define T0C_IDX_CNT 8'h33
`define T0C_IDX_FLAGS 8'h34
`define T0C_F_COMA_HI 7
`define T0C_F_COMA_LO 6
`define T0C_F_COMB_HI 5
`define T0C_F_COMB_LO 4
`define T0C_F_WGM_HI 1
`define T0C_F_WGM_LO 0
`define T0C_F_TSM 7
`define T0C_F_PSR 0
`define T0C_F_TOPBIT 3
`define T0C_F_FLAG_A 1
`define T0C_F_FLAG_B 0
`define T0C_RST_BYTE 8'h00
`define T0C_RST_COM 2'h0
`define T0C_RST_WGM 2'h0
`define T0C_MAX 8'hff
`define T0C_BOTTOM 8'h00
`define T0C_WGM_PC_MAX 3'h1
`define T0C_WGM_CTC 3'h2
`define T0C_WGM_FAST_MAX 3'h3
`define T0C_WGM_PC_OCA 3'h5
`define T0C_WGM_FAST_OCA 3'h7
`define T0C_DEF_PRESCALE 8
`endif

/* verilog/t0c_pkg.sv */
// Types shared by the timer compare-output modules
package t0c_pkg;
  typedef logic [1:0] t0c_com_t;
  typedef enum logic [1:0] {T0C_NORMAL, T0C_PCPWM, T0C_CTC, T0C_FAST} t0c_wave_t;
  typedef enum logic {T0C_BUS_IDLE, T0C_BUS_ACK} t0c_bus_t;
endpackage : t0c_pkg

/* verilog/t0c_timer_if.sv */
// Counter state carried from the timer core to its compare units
`timescale 1ns/10ps
interface t0c_timer_if (input wire logic ref_clk, input wire logic rst);
  import t0c_pkg::*;
  logic tick;
  logic count_up;
  logic wrap_evt;
  logic block;
  logic top_bit;
  t0c_wave_t wave;
  logic [7:0] cnt;
  logic [7:0] top;
  modport src (input ref_clk, rst, output tick, count_up, wrap_evt, block, top_bit, wave, cnt,
    top);
  modport dst (input ref_clk, rst, tick, count_up, wrap_evt, block, top_bit, wave, cnt, top);
endinterface : t0c_timer_if

/* verilog/t0c_prescaler.sv */
// Tick divider that stops and restarts from zero while held in reset
`timescale 1ns/10ps
`include "t0c_params.svh"
module t0c_prescaler #(
  parameter int DIV = `T0C_DEF_PRESCALE
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic hold,
  // Timer enable
  output logic tick
);
  import t0c_pkg::*;
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] div_r;
  logic [W-1:0] div_nxt;

  // Held divider gives no tick, so the counter cannot advance
  assign tick = !hold && (div_r == LAST);
  assign div_nxt = (hold || div_r == LAST) ? '0 : div_r + W'(1);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) div_r <= '0;
    else div_r <= div_nxt;
  end

  property p_hold_no_tick;
    @(posedge ref_clk) disable iff (rst) hold |-> !tick;
  endproperty
  a_hold_no_tick: assert property (p_hold_no_tick) else $error("tick while held");
endmodule : t0c_prescaler

/* verilog/t0c_cmp_unit.sv */
// One compare channel: match detection, waveform state and pin override
`timescale 1ns/10ps
module t0c_cmp_unit #(
  parameter bit HAS_TOGGLE = 1'b1
) (
  // Timer state
  t0c_timer_if.dst tmr,
  // Channel setup
  input wire t0c_pkg::t0c_com_t out_mode,
  input wire logic [7:0] cmp_value,
  // Normal port function
  input wire logic port_dir,
  input wire logic port_data,
  // Results
  output logic match_evt,
  output logic pin_out,
  output logic pin_oe
);
  import t0c_pkg::*;
  logic state_r;
  logic state_nxt;
  logic pin_r;
  logic oe_r;

  wire is_pwm = (tmr.wave == T0C_FAST) || (tmr.wave == T0C_PCPWM);
  wire toggle_ok = !is_pwm || (HAS_TOGGLE && tmr.top_bit);
  wire connected = (out_mode != 2'b00) && !((out_mode == 2'b01) && !toggle_ok);
  wire at_top_cmp = is_pwm && out_mode[1] && (cmp_value == tmr.top);
  wire hit = tmr.tick && (tmr.cnt == cmp_value) && !tmr.block;
  wire act = hit && !at_top_cmp;
  wire pc_top = tmr.tick && (tmr.cnt == tmr.top);

  assign match_evt = hit;
  assign pin_out = pin_r;
  assign pin_oe = oe_r;

  // State holds while disconnected, so reconnecting shows the last level it had
  always_comb begin
    state_nxt = state_r;
    case (tmr.wave)
      T0C_FAST: begin
        if (tmr.wrap_evt && out_mode[1]) state_nxt = ~out_mode[0];
        else if (act && out_mode[1]) state_nxt = out_mode[0];
        else if (act && out_mode == 2'b01 && toggle_ok) state_nxt = ~state_r;
      end
      T0C_PCPWM: begin
        if (at_top_cmp && pc_top) state_nxt = ~out_mode[0];
        else if (act && out_mode[1]) state_nxt = out_mode[0] ^ ~tmr.count_up;
        else if (act && out_mode == 2'b01 && toggle_ok) state_nxt = ~state_r;
      end
      default: begin
        if (act && out_mode == 2'b01) state_nxt = ~state_r;
        else if (act && out_mode[1]) state_nxt = out_mode[0];
      end
    endcase
  end

  always_ff @(posedge tmr.ref_clk or posedge tmr.rst) begin
    if (tmr.rst) begin
      state_r <= 1'b0;
      pin_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pin_r <= connected ? state_nxt : port_data;
      oe_r <= port_dir;
    end
  end

  property p_disc_port;
    @(posedge tmr.ref_clk) disable iff (tmr.rst)
      !connected |=> pin_out == $past(port_data);
  endproperty
  a_disc_port: assert property (p_disc_port) else $error("port data not passed");
  property p_set_on_match;
    @(posedge tmr.ref_clk) disable iff (tmr.rst)
      (!is_pwm && hit && out_mode == 2'b11) |=> state_r ##1 1'b1;
  endproperty
  a_set_on_match: assert property (p_set_on_match) else $error("set on match missed");
  property p_top_ignored;
    @(posedge tmr.ref_clk) disable iff (tmr.rst)
      (tmr.wave == T0C_FAST && at_top_cmp && !tmr.wrap_evt) |=> $stable(state_r);
  endproperty
  a_top_ignored: assert property (p_top_ignored) else $error("top match not ignored");
endmodule : t0c_cmp_unit

/* verilog/t0c_top.sv */
// Timer core, register slave and both compare channels
`timescale 1ns/10ps
`include "t0c_params.svh"
module t0c_top #(
  parameter int PRESCALE_DIV = `T0C_DEF_PRESCALE
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Port fallback for the two pins
  input wire logic port_dir_a,
  input wire logic port_data_a,
  input wire logic port_dir_b,
  input wire logic port_data_b,
  // Compare pins
  output logic compare_a_output,
  output logic compare_a_output_oe,
  output logic compare_b_output,
  output logic compare_b_output_oe
);
  import t0c_pkg::*;

  t0c_timer_if tmr (.ref_clk(ref_clk), .rst(rst));

  t0c_bus_t bus_r;
  t0c_bus_t bus_nxt;
  logic [31:0] rdata_r;
  t0c_com_t compare_a_output_mode_r;
  t0c_com_t compare_b_output_mode_r;
  logic [1:0] wgm_low_r;
  logic waveform_mode_top_bit_r;
  logic sync_hold_mode_r;
  logic sync_hold_mode_nxt;
  logic prescaler_reset_request_r;
  logic prescaler_reset_request_nxt;
  logic [7:0] compare_value_a_r;
  logic [7:0] compare_value_b_r;
  logic [7:0] counter_value_r;
  logic [7:0] counter_value_nxt;
  logic up_r;
  logic up_nxt;
  logic block_r;
  logic match_a_flag_r;
  logic match_b_flag_r;
  logic match_a_evt;
  logic match_b_evt;

  // Address decode: each register is one word at four times its index
  wire [7:0] idx = avs_address[9:2];
  wire aligned = avs_address[1:0] == 2'b00;
  wire sel_ctla = aligned && idx == `T0C_IDX_CTRL_A;
  wire sel_gctl = aligned && idx == `T0C_IDX_GCTL;
  wire sel_ctlb = aligned && idx == `T0C_IDX_CTRL_B;
  wire sel_cmpa = aligned && idx == `T0C_IDX_CMP_A;
  wire sel_cmpb = aligned && idx == `T0C_IDX_CMP_B;
  wire sel_cnt = aligned && idx == `T0C_IDX_CNT;
  wire sel_flag = aligned && idx == `T0C_IDX_FLAGS;
  wire [7:0] wd = avs_writedata[7:0];
  wire wr_go = avs_write && bus_r == T0C_BUS_ACK && avs_byteenable[0];
  wire wr_ctla = wr_go && sel_ctla;
  wire wr_gctl = wr_go && sel_gctl;
  wire wr_ctlb = wr_go && sel_ctlb;
  wire cnt_wr = wr_go && sel_cnt;
  wire clr_a = wr_go && sel_flag && wd[`T0C_F_FLAG_A];
  wire clr_b = wr_go && sel_flag && wd[`T0C_F_FLAG_B];

  wire [7:0] ctla_rd = {compare_a_output_mode_r, compare_b_output_mode_r, 2'b00,
    wgm_low_r};
  wire [7:0] gctl_rd = {sync_hold_mode_r, 6'h00, prescaler_reset_request_r};
  wire [7:0] ctlb_rd = {4'h0, waveform_mode_top_bit_r, 3'h0};
  wire [7:0] flag_rd = {6'h00, match_a_flag_r, match_b_flag_r};
  wire [7:0] rd_mux = sel_ctla ? ctla_rd :
    sel_gctl ? gctl_rd :
    sel_ctlb ? ctlb_rd :
    sel_cmpa ? compare_value_a_r :
    sel_cmpb ? compare_value_b_r :
    sel_cnt ? counter_value_r :
    sel_flag ? flag_rd : `T0C_RST_BYTE;

  // One wait cycle lets read data come from a flop
  assign avs_waitrequest = (avs_read || avs_write) && bus_r != T0C_BUS_ACK;
  assign avs_readdata = rdata_r;

  always_comb begin
    bus_nxt = bus_r;
    case (bus_r)
      T0C_BUS_IDLE: if (avs_read || avs_write) bus_nxt = T0C_BUS_ACK;
      T0C_BUS_ACK: bus_nxt = T0C_BUS_IDLE;
      default: bus_nxt = T0C_BUS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_r <= T0C_BUS_IDLE;
      rdata_r <= 32'h0000_0000;
    end else begin
      bus_r <= bus_nxt;
      if (bus_r == T0C_BUS_IDLE && avs_read) rdata_r <= {24'h00_0000, rd_mux};
    end
  end

  // Waveform mode decode
  wire [2:0] wgm_sel = {waveform_mode_top_bit_r, wgm_low_r};
  wire is_fast = wgm_sel == `T0C_WGM_FAST_MAX || wgm_sel == `T0C_WGM_FAST_OCA;
  wire is_pc = wgm_sel == `T0C_WGM_PC_MAX || wgm_sel == `T0C_WGM_PC_OCA;
  wire top_is_a = wgm_sel == `T0C_WGM_CTC || wgm_sel == `T0C_WGM_PC_OCA ||
    wgm_sel == `T0C_WGM_FAST_OCA;
  // Reserved codes 4 and 6 fall back to free counting
  t0c_wave_t wave;
  assign wave = is_fast ? T0C_FAST : is_pc ? T0C_PCPWM :
    (wgm_sel == `T0C_WGM_CTC) ? T0C_CTC : T0C_NORMAL;
  wire [7:0] top_val = top_is_a ? compare_value_a_r : `T0C_MAX;

  assign tmr.wave = wave;
  assign tmr.top = top_val;
  assign tmr.cnt = counter_value_r;
  assign tmr.top_bit = waveform_mode_top_bit_r;
  assign tmr.block = block_r;
  assign tmr.count_up = is_pc ? up_r : 1'b1;
  assign tmr.wrap_evt = tmr.tick && is_fast && counter_value_r == top_val;

  // Prescaler and sync hold control
  always_comb begin
    sync_hold_mode_nxt = sync_hold_mode_r;
    prescaler_reset_request_nxt = prescaler_reset_request_r;
    if (wr_gctl) begin
      sync_hold_mode_nxt = wd[`T0C_F_TSM];
      prescaler_reset_request_nxt = wd[`T0C_F_PSR];
    end else if (!sync_hold_mode_r) begin
      prescaler_reset_request_nxt = 1'b0;
    end
  end

  t0c_prescaler #(.DIV(PRESCALE_DIV)) u_presc (
    .ref_clk(ref_clk),
    .rst(rst),
    .hold(prescaler_reset_request_r),
    .tick(tmr.tick)
  );

  // Counter: a bus write wins over the tick and masks the next match
  always_comb begin
    counter_value_nxt = counter_value_r;
    up_nxt = up_r;
    if (cnt_wr) begin
      counter_value_nxt = wd;
    end else if (tmr.tick) begin
      case (wave)
        T0C_PCPWM: begin
          if (up_r && counter_value_r >= top_val) begin
            up_nxt = 1'b0;
            counter_value_nxt = (counter_value_r == `T0C_BOTTOM) ? `T0C_BOTTOM :
              counter_value_r - 8'h01;
          end else if (!up_r && counter_value_r == `T0C_BOTTOM) begin
            up_nxt = 1'b1;
            counter_value_nxt = counter_value_r + 8'h01;
          end else begin
            counter_value_nxt = up_r ? counter_value_r + 8'h01 : counter_value_r - 8'h01;
          end
        end
        T0C_CTC, T0C_FAST: begin
          up_nxt = 1'b1;
          counter_value_nxt = (counter_value_r == top_val) ? `T0C_BOTTOM :
            counter_value_r + 8'h01;
        end
        default: begin
          up_nxt = 1'b1;
          counter_value_nxt = counter_value_r + 8'h01;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      compare_a_output_mode_r <= `T0C_RST_COM;
      compare_b_output_mode_r <= `T0C_RST_COM;
      wgm_low_r <= `T0C_RST_WGM;
      waveform_mode_top_bit_r <= 1'b0;
      compare_value_a_r <= `T0C_RST_BYTE;
      compare_value_b_r <= `T0C_RST_BYTE;
    end else begin
      if (wr_ctla) begin
        compare_a_output_mode_r <= wd[`T0C_F_COMA_HI:`T0C_F_COMA_LO];
        compare_b_output_mode_r <= wd[`T0C_F_COMB_HI:`T0C_F_COMB_LO];
        wgm_low_r <= wd[`T0C_F_WGM_HI:`T0C_F_WGM_LO];
      end
      if (wr_ctlb) waveform_mode_top_bit_r <= wd[`T0C_F_TOPBIT];
      if (wr_go && sel_cmpa) compare_value_a_r <= wd;
      if (wr_go && sel_cmpb) compare_value_b_r <= wd;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_hold_mode_r <= 1'b0;
      prescaler_reset_request_r <= 1'b0;
      counter_value_r <= `T0C_BOTTOM;
      up_r <= 1'b1;
      block_r <= 1'b0;
      match_a_flag_r <= 1'b0;
      match_b_flag_r <= 1'b0;
    end else begin
      sync_hold_mode_r <= sync_hold_mode_nxt;
      prescaler_reset_request_r <= prescaler_reset_request_nxt;
      counter_value_r <= counter_value_nxt;
      up_r <= up_nxt;
      block_r <= cnt_wr || (block_r && !tmr.tick);
      // A match in the clearing cycle still sets the flag
      match_a_flag_r <= match_a_evt || (match_a_flag_r && !clr_a);
      match_b_flag_r <= match_b_evt || (match_b_flag_r && !clr_b);
    end
  end

  t0c_cmp_unit #(.HAS_TOGGLE(1'b1)) u_cmp_a (
    .tmr(tmr),
    .out_mode(compare_a_output_mode_r),
    .cmp_value(compare_value_a_r),
    .port_dir(port_dir_a),
    .port_data(port_data_a),
    .match_evt(match_a_evt),
    .pin_out(compare_a_output),
    .pin_oe(compare_a_output_oe)
  );

  // Channel B has no toggle option in the PWM modes
  t0c_cmp_unit #(.HAS_TOGGLE(1'b0)) u_cmp_b (
    .tmr(tmr),
    .out_mode(compare_b_output_mode_r),
    .cmp_value(compare_value_b_r),
    .port_dir(port_dir_b),
    .port_data(port_data_b),
    .match_evt(match_b_evt),
    .pin_out(compare_b_output),
    .pin_oe(compare_b_output_oe)
  );

  property p_psr_autoclr;
    @(posedge ref_clk) disable iff (rst)
      (prescaler_reset_request_r && !sync_hold_mode_r && !wr_gctl) |=> !prescaler_reset_request_r;
  endproperty
  a_psr_autoclr: assert property (p_psr_autoclr) else $error("reset bit not cleared");
  property p_tsm_keeps;
    @(posedge ref_clk) disable iff (rst)
      (sync_hold_mode_r && prescaler_reset_request_r && !wr_gctl) |=> prescaler_reset_request_r;
  endproperty
  a_tsm_keeps: assert property (p_tsm_keeps) else $error("reset bit lost in hold mode");
  property p_tsm_release;
    @(posedge ref_clk) disable iff (rst)
      (wr_gctl && !wd[`T0C_F_TSM] && !wd[`T0C_F_PSR]) |=> !prescaler_reset_request_r;
  endproperty
  a_tsm_release: assert property (p_tsm_release) else $error("release left reset set");
  property p_halted;
    @(posedge ref_clk) disable iff (rst)
      (prescaler_reset_request_r && !cnt_wr) |=> $stable(counter_value_r);
  endproperty
  a_halted: assert property (p_halted) else $error("counter moved while held");
  property p_sync_step;
    @(posedge ref_clk) disable iff (rst)
      (!tmr.tick && !cnt_wr) |=> $stable(counter_value_r);
  endproperty
  a_sync_step: assert property (p_sync_step) else $error("counter moved without tick");
  property p_ctc_clear;
    @(posedge ref_clk) disable iff (rst)
      (wave == T0C_CTC && tmr.tick && counter_value_r == compare_value_a_r && !cnt_wr &&
        !block_r) |=> counter_value_r == `T0C_BOTTOM && match_a_flag_r;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("compare A did not clear");
  property p_flag_b;
    @(posedge ref_clk) disable iff (rst) match_b_evt |=> match_b_flag_r;
  endproperty
  a_flag_b: assert property (p_flag_b) else $error("flag B not set");
  property p_fast_oca;
    @(posedge ref_clk) disable iff (rst)
      wgm_sel == `T0C_WGM_FAST_OCA |-> wave == T0C_FAST && top_val == compare_value_a_r;
  endproperty
  a_fast_oca: assert property (p_fast_oca) else $error("mode 7 decode wrong");
  property p_pc_turn;
    @(posedge ref_clk) disable iff (rst)
      (wave == T0C_PCPWM && tmr.tick && up_r && counter_value_r == `T0C_MAX &&
        top_val == `T0C_MAX && !cnt_wr) |=> !up_r && counter_value_r == 8'hfe;
  endproperty
  a_pc_turn: assert property (p_pc_turn) else $error("no turn at top");
  property p_rsvd_zero;
    @(posedge ref_clk) disable iff (rst)
      (bus_r == T0C_BUS_IDLE && avs_read && sel_ctla) |=> avs_readdata[3:2] == 2'b00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");
endmodule : t0c_top

/* tb/t0c_pin_load.sv */
// External load on one compare pin: a weak pull-down behind the driver
`timescale 1ns/10ps
module t0c_pin_load (
  // Device side
  input wire logic drv,
  input wire logic drv_oe,
  // Wire level
  output logic level
);
  // A released pin falls to the pull-down instead of keeping its last level
  assign level = drv_oe ? drv : 1'b0;
endmodule : t0c_pin_load

/* tb/t0c_top_tb.sv */
// Register-level bench for the timer compare-output block
`timescale 1ns/10ps
`include "t0c_params.svh"
module t0c_top_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic port_dir_a = 1'b1;
  logic port_data_a = 1'b1;
  logic port_dir_b = 1'b1;
  logic port_data_b = 1'b0;
  logic compare_a_output;
  logic compare_a_output_oe;
  logic compare_b_output;
  logic compare_b_output_oe;
  logic [1:0] level;
  int err_count = 0;
  int checks_done = 0;
  int ca;
  int cb;
  logic [7:0] q8;
  logic [7:0] c0;
  logic [1:0] pw_wgm [6] = '{2'h3, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1};
  logic [7:0] pw_cmp [6] = '{8'h40, 8'h40, 8'hff, 8'h40, 8'h40, 8'hff};
  logic [1:0] pw_com [6] = '{2'h2, 2'h3, 2'h2, 2'h2, 2'h3, 2'h2};
  int pw_win [6] = '{256, 256, 256, 510, 510, 510};
  int pw_exp [6] = '{65, 191, 256, 128, 382, 510};
  int ea [4] = '{512, 256, 0, 512};

  // Divider of one keeps every waveform period short
  t0c_top #(.PRESCALE_DIV(1)) t0c_top_i (.ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port_dir_a(port_dir_a), .port_data_a(port_data_a), .port_dir_b(port_dir_b),
    .port_data_b(port_data_b), .compare_a_output(compare_a_output),
    .compare_a_output_oe(compare_a_output_oe), .compare_b_output(compare_b_output),
    .compare_b_output_oe(compare_b_output_oe));

  t0c_pin_load t0c_pin_load_i [1:0] (.drv({compare_b_output, compare_a_output}),
    .drv_oe({compare_b_output_oe, compare_a_output_oe}), .level(level));

  always #5 ref_clk = ~ref_clk;

  task complete_run();
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Pin high-time counts carry up to three cycles of pipeline slack
  task chk_near(input int got, input int exp);
    checks_done++;
    if (got < exp - 3 || got > exp + 3) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_near

  task bus(input logic wr_en, input logic [7:0] idx, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr_en;
    avs_read <= ~wr_en;
    avs_writedata <= {24'h000000, d};
    #1;
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 50) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, avs_waitrequest, 1'b0);
      complete_run();
    end
    @(posedge ref_clk);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task rd(input logic [7:0] idx, output logic [7:0] q);
    bus(1'b0, idx, 8'h00, q);
  endtask : rd

  // High cycles of both pin wires over a window
  task measure(input int win);
    ca = 0;
    cb = 0;
    repeat (win) begin
      @(posedge ref_clk);
      #1;
      ca += (level[0] === 1'b1) ? 1 : 0;
      cb += (level[1] === 1'b1) ? 1 : 0;
    end
  endtask : measure

  initial begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    complete_run();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`T0C_IDX_CTRL_A, q8);
    chk(q8, 8'h00);
    rd(`T0C_IDX_GCTL, q8);
    chk(q8, 8'h00);
    rd(8'h3f, q8);
    chk(q8, 8'h00);
    wr(`T0C_IDX_CTRL_A, 8'hff);
    rd(`T0C_IDX_CTRL_A, q8);
    chk(q8, 8'hf3);
    wr(`T0C_IDX_GCTL, 8'h81);
    rd(`T0C_IDX_GCTL, q8);
    chk(q8, 8'h81);
    rd(`T0C_IDX_CNT, c0);
    repeat (20) @(posedge ref_clk);
    rd(`T0C_IDX_CNT, q8);
    chk(q8, c0);
    wr(`T0C_IDX_FLAGS, 8'h03);
    rd(`T0C_IDX_FLAGS, q8);
    chk(q8, 8'h00);
    wr(`T0C_IDX_GCTL, 8'h00);
    rd(`T0C_IDX_GCTL, q8);
    chk(q8, 8'h00);
    rd(`T0C_IDX_CNT, q8);
    chk({31'h0, q8 != c0}, 32'h1);
    wr(`T0C_IDX_GCTL, 8'h01);
    rd(`T0C_IDX_GCTL, q8);
    chk(q8, 8'h00);
    // Counter limited by compare A once the clear-on-match mode is on
    wr(`T0C_IDX_CMP_A, 8'h10);
    wr(`T0C_IDX_CMP_B, 8'h08);
    wr(`T0C_IDX_CTRL_A, 8'h02);
    // Counter may sit above compare A here; restart it so the clear is reached
    wr(`T0C_IDX_CNT, 8'h00);
    repeat (100) @(posedge ref_clk);
    rd(`T0C_IDX_CNT, q8);
    chk({31'h0, q8 <= 8'h10}, 32'h1);
    rd(`T0C_IDX_FLAGS, q8);
    chk(q8, 8'h03);
    for (int m = 0; m < 4; m++) begin
      wr(`T0C_IDX_CTRL_A, {m[1:0], m[1:0], 4'h0});
      repeat (300) @(posedge ref_clk);
      measure(512);
      chk_near(ca, ea[m]);
      chk_near(cb, (m == 0) ? 0 : ea[m]);
    end
    for (int i = 0; i < 6; i++) begin
      wr(`T0C_IDX_CMP_A, pw_cmp[i]);
      wr(`T0C_IDX_CMP_B, pw_cmp[i]);
      wr(`T0C_IDX_CTRL_A, {pw_com[i], pw_com[i], 2'b00, pw_wgm[i]});
      repeat (600) @(posedge ref_clk);
      measure(pw_win[i]);
      chk_near(ca, pw_exp[i]);
      chk_near(cb, pw_exp[i]);
    end
    // Toggle mode without the top waveform bit leaves the port in charge
    wr(`T0C_IDX_CTRL_A, 8'h43);
    repeat (20) @(posedge ref_clk);
    measure(256);
    chk_near(ca, 256);
    wr(`T0C_IDX_CTRL_B, 8'h08);
    wr(`T0C_IDX_CMP_A, 8'h3f);
    wr(`T0C_IDX_CMP_B, 8'h1f);
    wr(`T0C_IDX_CTRL_A, 8'h63);
    repeat (600) @(posedge ref_clk);
    measure(128);
    chk_near(ca, 64);
    chk_near(cb, 64);
    // Dual slope with compare A as top: A stays high, B high for twice its compare
    wr(`T0C_IDX_CTRL_A, 8'ha1);
    repeat (300) @(posedge ref_clk);
    measure(252);
    chk_near(ca, 252);
    chk_near(cb, 124);
    @(posedge ref_clk);
    port_dir_a <= 1'b0;
    port_dir_b <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    chk(compare_a_output_oe, 1'b0);
    chk(compare_b_output_oe, 1'b0);
    chk(level, 2'b00);
    complete_run();
  end
endmodule : t0c_top_tb
